// [design/boundary_scan_test_port.sv]
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - Eight-cell instruction register selects test and data register.
// - Codes 00/01 boundary, 03 ident, FF bypass, 80-FE debug, rest reserved.
// - Instruction bits shift in least significant bit first.
// - One-cell bypass between serial in and out during bypass data shift.
// - Boundary chain is one serial path of 87 cells.
// - Four enable cells gate outputs in test; 1 enables, default 1.
// - Serial in enters boundary cell 0; top cell feeds serial out.
// - Shifted pattern drives pins; capture loads pin values into chain.
// - Ident register 32 bits: version, product, maker, constant 1.
// - Ident value leaves least significant bit first.
// - Data scan path is the register chosen by current instruction.
// - Serial in and mode select sampled on test clock rising edges.
// - Serial out changes only on test clock falling edges.
// - Test logic runs from the test clock, found by edge detection.
// - Sixteen-state controller steered by mode select.
// - Test reset low forces controller reset without test clock edges.
// - Five rising edges with mode select high reach reset and stay.
// - Reset state loads ident instruction into instruction latch.
// - Instruction capture loads 01 into two low bits.
// - Data update on falling edge; parallel outputs stable while shifting.
module boundary_scan_test_port #(
	parameter logic [3:0]  ID_VERSION = 4'h1,   // Arbitrary value
	parameter logic [15:0] ID_PRODUCT = 16'h1234, // Arbitrary value
	parameter logic [10:0] ID_MAKER   = 11'h0AB  // Arbitrary value
) (
	input  wire logic                            clk,
	input  wire logic                            reset_n,
	input  wire logic                            test_clock_in,
	input  wire logic                            test_mode_select,
	input  wire logic                            test_serial_in,
	input  wire logic                            test_reset_n,
	output logic                                 test_serial_out,
	input  wire logic [scan_port_pkg::PAD_CELLS-1:0] pad_in,
	input  wire logic [scan_port_pkg::PAD_CELLS-1:0] core_pad_out,
	output logic [scan_port_pkg::PAD_CELLS-1:0]  pad_out,
	output logic [scan_port_pkg::OE_CELLS-1:0]   scan_output_enable_cells,
	input  wire logic                            wb_cyc_i,
	input  wire logic                            wb_stb_i,
	input  wire logic                            wb_we_i,
	input  wire logic [7:0]                      wb_adr_i,
	input  wire logic [3:0]                      wb_sel_i,
	input  wire logic [31:0]                     wb_dat_i,
	output logic [31:0]                          wb_dat_o,
	output logic                                 wb_ack_o
);
	import scan_port_pkg::*;

	localparam logic [ID_LEN-1:0] ID_VALUE = {ID_VERSION, ID_PRODUCT, ID_MAKER, 1'b1};

	typedef struct packed {
		logic                 tck_s1;
		logic                 tck_s2;
		logic                 tck_d;
		logic                 tms_s1;
		logic                 tms_s2;
		logic                 tdi_s1;
		logic                 tdi_s2;
		logic                 trst_s1;
		logic                 trst_s2;
		logic [PAD_CELLS-1:0] pad_s1;
		logic [PAD_CELLS-1:0] pad_s2;
		tap_state_t           state;
		logic [2:0]           tms_cnt;
		logic [IR_LEN-1:0]    ir_shift;
		logic [IR_LEN-1:0]    instr;
		logic                 bypass;
		logic [BSR_LEN-1:0]   bsr_shift;
		logic [BSR_LEN-1:0]   bsr_upd;
		logic [ID_LEN-1:0]    id_shift;
		logic                 tdo;
		logic [PAD_CELLS-1:0] pad_drv;
		logic [OE_CELLS-1:0]  oe;
		logic                 hold;
		logic                 ack;
		logic [31:0]          dat;
	} regs_t;

	localparam regs_t REGS_INIT = '{
		state:   TAP_RESET,
		instr:   INSTR_IDCODE,
		bsr_upd: {{PAD_CELLS{1'b0}}, OE_RESET},
		oe:      OE_RESET,
		hold:    CTRL_RESET,
		default: '0
	};

	regs_t r_reg;
	regs_t r_next;
	logic  rise;
	logic  fall;
	logic  extest;
	logic  dr_out;
	logic  req;

	// Controller state graph
	function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
		case (s)
			TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
			TAP_IDLE:  tap_next = m ? SEL_DR : TAP_IDLE;
			SEL_DR:    tap_next = m ? SEL_IR : CAP_DR;
			CAP_DR:    tap_next = m ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR:  tap_next = m ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR:  tap_next = m ? UPD_DR : PAUSE_DR;
			PAUSE_DR:  tap_next = m ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR:  tap_next = m ? UPD_DR : SHIFT_DR;
			UPD_DR:    tap_next = m ? SEL_DR : TAP_IDLE;
			SEL_IR:    tap_next = m ? TAP_RESET : CAP_IR;
			CAP_IR:    tap_next = m ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR:  tap_next = m ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR:  tap_next = m ? UPD_IR : PAUSE_IR;
			PAUSE_IR:  tap_next = m ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR:  tap_next = m ? UPD_IR : SHIFT_IR;
			UPD_IR:    tap_next = m ? SEL_DR : TAP_IDLE;
			default:   tap_next = TAP_RESET;
		endcase
	endfunction

	// Reserved and debug codes fall back to bypass
	function automatic logic [1:0] dr_sel(input logic [IR_LEN-1:0] code);
		if (code == INSTR_EXTEST || code == INSTR_SAMPLE) begin
			dr_sel = DR_BOUNDARY;
		end else if (code == INSTR_IDCODE) begin
			dr_sel = DR_IDENT;
		end else begin
			dr_sel = DR_BYPASS;
		end
	endfunction

	// Edges of the sampled test clock, third stage against second
	assign rise = r_reg.tck_s2 & ~r_reg.tck_d;
	assign fall = ~r_reg.tck_s2 & r_reg.tck_d;
	assign extest = (r_reg.instr == INSTR_EXTEST);
	assign req = wb_cyc_i & wb_stb_i & ~r_reg.ack;

	// Serial output of the selected data register
	always_comb begin
		case (dr_sel(r_reg.instr))
			DR_BOUNDARY: dr_out = r_reg.bsr_shift[BSR_LEN-1];
			DR_IDENT:    dr_out = r_reg.id_shift[0];
			default:     dr_out = r_reg.bypass;
		endcase
	end

	// Whole next-state computation
	always_comb begin
		r_next = r_reg;
		// Pins are asynchronous, two stages each
		r_next.tck_s1  = test_clock_in;
		r_next.tck_s2  = r_reg.tck_s1;
		r_next.tck_d   = r_reg.tck_s2;
		r_next.tms_s1  = test_mode_select;
		r_next.tms_s2  = r_reg.tms_s1;
		r_next.tdi_s1  = test_serial_in;
		r_next.tdi_s2  = r_reg.tdi_s1;
		r_next.trst_s1 = test_reset_n;
		r_next.trst_s2 = r_reg.trst_s1;
		r_next.pad_s1  = pad_in;
		r_next.pad_s2  = r_reg.pad_s1;

		// Rising edge: sample mode select and serial in
		if (rise) begin
			r_next.state = tap_next(r_reg.state, r_reg.tms_s2);
			if (r_reg.tms_s2) begin
				if (r_reg.tms_cnt != TMS_RESET_EDGES) begin
					r_next.tms_cnt = r_reg.tms_cnt + 3'h1;
				end
			end else begin
				r_next.tms_cnt = 3'h0;
			end
			case (r_reg.state)
				CAP_IR: begin
					r_next.ir_shift = IR_CAPTURE;
				end
				SHIFT_IR: begin
					r_next.ir_shift = {r_reg.tdi_s2, r_reg.ir_shift[IR_LEN-1:1]};
				end
				CAP_DR: begin
					r_next.bypass = 1'b0;
					if (dr_sel(r_reg.instr) == DR_BOUNDARY) begin
						// Pin values in, enable cells from their latch
						r_next.bsr_shift = {r_reg.pad_s2, r_reg.bsr_upd[OE_CELLS-1:0]};
					end
					if (dr_sel(r_reg.instr) == DR_IDENT) begin
						r_next.id_shift = ID_VALUE;
					end
				end
				SHIFT_DR: begin
					case (dr_sel(r_reg.instr))
						DR_BOUNDARY: begin
							r_next.bsr_shift = {r_reg.bsr_shift[BSR_LEN-2:0], r_reg.tdi_s2};
						end
						DR_IDENT: begin
							r_next.id_shift = {r_reg.tdi_s2, r_reg.id_shift[ID_LEN-1:1]};
						end
						default: begin
							r_next.bypass = r_reg.tdi_s2;
						end
					endcase
				end
				default: begin
				end
			endcase
		end

		// Falling edge: drive serial out, load parallel latches
		if (fall) begin
			if (r_reg.state == SHIFT_IR) begin
				r_next.tdo = r_reg.ir_shift[0];
			end else if (r_reg.state == SHIFT_DR) begin
				r_next.tdo = dr_out;
			end
			if (r_reg.state == UPD_IR) begin
				r_next.instr = r_reg.ir_shift;
			end
			if (r_reg.state == UPD_DR && dr_sel(r_reg.instr) == DR_BOUNDARY) begin
				r_next.bsr_upd = r_reg.bsr_shift;
			end
		end

		// Reset state keeps the ident instruction selected
		if (r_reg.state == TAP_RESET) begin
			r_next.instr = INSTR_IDCODE;
		end

		// Test reset needs only the system clock, no test clock edge
		if (!r_reg.trst_s2 || r_reg.hold) begin
			r_next.state = TAP_RESET;
			r_next.tms_cnt = 3'h0;
		end

		// Pins follow the core unless external test is active
		if (extest) begin
			r_next.pad_drv = r_reg.bsr_upd[BSR_LEN-1:OE_CELLS];
			r_next.oe = r_reg.bsr_upd[OE_CELLS-1:0];
		end else begin
			r_next.pad_drv = core_pad_out;
			r_next.oe = OE_RESET;
		end

		// Wishbone slave, ack one cycle after the request
		r_next.ack = req;
		if (req) begin
			if (wb_adr_i == CTRL_OFFSET) begin
				r_next.dat = {31'h0000_0000, r_reg.hold};
				if (wb_we_i && wb_sel_i[0]) begin
					r_next.hold = wb_dat_i[CTRL_HOLD_BIT];
				end
			end else if (wb_adr_i == STATUS_OFFSET) begin
				r_next.dat = {8'h00, r_reg.instr, r_reg.state};
			end else begin
				r_next.dat = 32'h0000_0000; // Unmapped reads zero
			end
		end
	end

	// Single register bank for all state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r_reg <= REGS_INIT;
		end else begin
			r_reg <= r_next;
		end
	end

	assign test_serial_out = r_reg.tdo;
	assign pad_out = r_reg.pad_drv;
	assign scan_output_enable_cells = r_reg.oe;
	assign wb_dat_o = r_reg.dat;
	assign wb_ack_o = r_reg.ack;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// Controller checks
	property p_trst;
		!r_reg.trst_s2 |=> r_reg.state == TAP_RESET;
	endproperty
	a_trst: assert property (p_trst) else $error("test reset ignored");

	property p_tms_five;
		r_reg.tms_cnt == TMS_RESET_EDGES |-> r_reg.state == TAP_RESET;
	endproperty
	a_tms_five: assert property (p_tms_five) else $error("five edges no reset");

	property p_reset_instr;
		r_reg.state == TAP_RESET |=> r_reg.instr == INSTR_IDCODE;
	endproperty
	a_reset_instr: assert property (p_reset_instr) else $error("no ident in reset");

	property p_ir_capture;
		rise && r_reg.state == CAP_IR |=> r_reg.ir_shift[1:0] == 2'b01;
	endproperty
	a_ir_capture: assert property (p_ir_capture) else $error("bad ir capture");

	// Data path checks
	property p_bypass;
		rise && r_reg.state == SHIFT_DR && r_reg.instr == INSTR_BYPASS
			|=> r_reg.bypass == $past(r_reg.tdi_s2);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass did not shift");

	property p_id_load;
		rise && r_reg.state == CAP_DR && r_reg.instr == INSTR_IDCODE
			|=> r_reg.id_shift == ID_VALUE && r_reg.id_shift[0];
	endproperty
	a_id_load: assert property (p_id_load) else $error("ident not loaded");

	property p_tdo_fall;
		$changed(r_reg.tdo) |-> $past(fall);
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off fall");

	property p_upd_stable;
		!(fall && r_reg.state == UPD_DR) |=> $stable(r_reg.bsr_upd);
	endproperty
	a_upd_stable: assert property (p_upd_stable) else $error("latch moved");

	property p_oe_normal;
		r_reg.instr != INSTR_EXTEST |=> r_reg.oe == OE_RESET;
	endproperty
	a_oe_normal: assert property (p_oe_normal) else $error("outputs gated");

	property p_ack_pulse;
		r_reg.ack |=> !r_reg.ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");

endmodule

// [inc/scan_port_pkg.sv]
package scan_port_pkg;

	// Chain lengths
	localparam int IR_LEN    = 8;
	localparam int ID_LEN    = 32;
	localparam int BSR_LEN   = 87;
	localparam int OE_CELLS  = 4;
	localparam int PAD_CELLS = BSR_LEN - OE_CELLS;

	// Instruction codes
	localparam logic [7:0] INSTR_EXTEST = 8'h00;
	localparam logic [7:0] INSTR_SAMPLE = 8'h01;
	localparam logic [7:0] INSTR_IDCODE = 8'h03;
	localparam logic [7:0] INSTR_BYPASS = 8'hFF;
	localparam logic [7:0] INSTR_DEBUG_LO = 8'h80;

	// Capture pattern of the instruction path
	localparam logic [7:0] IR_CAPTURE = 8'h01;

	// Data register selection codes
	localparam logic [1:0] DR_BYPASS   = 2'h0;
	localparam logic [1:0] DR_BOUNDARY = 2'h1;
	localparam logic [1:0] DR_IDENT    = 2'h2;

	// Output-enable cells default to enabled
	localparam logic [OE_CELLS-1:0] OE_RESET = 4'hF;

	// Register map, byte addresses
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam int CTRL_HOLD_BIT = 0;
	localparam logic CTRL_RESET = 1'b0;

	// Rising-edge count that forces reset
	localparam logic [2:0] TMS_RESET_EDGES = 3'h5;

	// Controller states, one-hot
	typedef enum logic [15:0] {
		TAP_RESET = 16'h0001,
		TAP_IDLE  = 16'h0002,
		SEL_DR    = 16'h0004,
		CAP_DR    = 16'h0008,
		SHIFT_DR  = 16'h0010,
		EXIT1_DR  = 16'h0020,
		PAUSE_DR  = 16'h0040,
		EXIT2_DR  = 16'h0080,
		UPD_DR    = 16'h0100,
		SEL_IR    = 16'h0200,
		CAP_IR    = 16'h0400,
		SHIFT_IR  = 16'h0800,
		EXIT1_IR  = 16'h1000,
		PAUSE_IR  = 16'h2000,
		EXIT2_IR  = 16'h4000,
		UPD_IR    = 16'h8000
	} tap_state_t;

endpackage

// [verification/scan_tester.sv]
`timescale 1ns/1ps
module scan_tester (
	input  wire logic clk,
	input  wire logic test_serial_out,
	output logic      test_clock_in,
	output logic      test_mode_select,
	output logic      test_serial_in
);
	// Test clock idles low between frames
	initial begin
		test_clock_in = 1'b0;
		test_mode_select = 1'b0;
		test_serial_in = 1'b0;
	end

	// One 200 ns test-clock period; edges sit half a system cycle off clk
	task automatic cycle(input logic m, input logic d, output logic q);
		@(negedge clk);
		#5;
		test_mode_select = m;
		test_serial_in = d;
		#90;
		q = test_serial_out;
		#5;
		test_clock_in = 1'b1;
		#100;
		test_clock_in = 1'b0;
	endtask
endmodule

// [verification/boundary_scan_test_port_bench.sv]
`timescale 1ns/1ps
module boundary_scan_test_port_bench;
	import scan_port_pkg::*;
	logic clk, reset_n, test_reset_n, tck, tms, tdi, tdo, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [PAD_CELLS-1:0] pad_in, core_pad_out, pad_out;
	logic [OE_CELLS-1:0]  enables;
	logic [7:0]           wb_adr_i;
	logic [3:0]           wb_sel_i;
	logic [31:0]          wb_dat_i, wb_dat_o, rd;
	logic [127:0]         q;
	logic [86:0]          preload;
	logic                 tdo_prev, tck_prev;
	int                   bad_count, checks_done;

	boundary_scan_test_port i_boundary_scan_test_port (.clk(clk), .reset_n(reset_n),
		.test_clock_in(tck), .test_mode_select(tms), .test_serial_in(tdi),
		.test_reset_n(test_reset_n), .test_serial_out(tdo), .pad_in(pad_in),
		.core_pad_out(core_pad_out), .pad_out(pad_out), .scan_output_enable_cells(enables),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	scan_tester i_scan_tester (.clk(clk), .test_serial_out(tdo), .test_clock_in(tck),
		.test_mode_select(tms), .test_serial_in(tdi));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Serial out may only move while the test clock is low
	always @(posedge clk) begin
		if (tck_prev === 1'b1 && tck === 1'b1 && tdo !== tdo_prev) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, tdo, tdo_prev);
		end
		tdo_prev <= tdo;
		tck_prev <= tck;
	end

	// Classic single cycle; the wait is bounded, a hang ends the run
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_sel_i <= 4'hF;
		wb_adr_i <= a;
		wb_dat_i <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (wb_ack_o === 1'b1) break;
		end
		if (i == 20) begin
			bad_count++;
			close_out();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask

	task automatic status(input logic [7:0] ins, input logic [15:0] st);
		wb(1'b0, STATUS_OFFSET, 32'h0000_0000);
		chk(rd, {8'h00, ins, st});
	endtask

	task automatic tk(input logic m);
		logic r;
		i_scan_tester.cycle(m, 1'b0, r);
	endtask

	// Scan from idle back to idle; rev sends the top bit first
	task automatic scan(input bit ir, input int n, input logic [127:0] din, input bit rev);
		int j;
		q = '0;
		tk(1'b1);
		if (ir) tk(1'b1);
		tk(1'b0);
		tk(1'b0);
		for (int k = 0; k < n; k++) begin
			j = rev ? n - 1 - k : k;
			i_scan_tester.cycle(k == n - 1, din[j], q[j]);
		end
		tk(1'b1);
		tk(1'b0);
	endtask

	task automatic t_ident();
		scan(1'b0, 32, '0, 1'b0);
		chk(q[31:0], 32'h1123_4157);
		status(INSTR_IDCODE, TAP_IDLE);
		$display("ident test done");
	endtask

	// Bypass plus codes that must fall back to it
	task automatic t_bypass();
		logic [7:0] codes [3];
		codes = '{INSTR_BYPASS, INSTR_DEBUG_LO, 8'h02};
		foreach (codes[c]) begin
			scan(1'b1, 8, codes[c], 1'b0);
			chk(q[7:0], IR_CAPTURE);
			scan(1'b0, 4, 4'hB, 1'b0);
			chk(q[3:0], 4'h6);
			status(codes[c], TAP_IDLE);
		end
		$display("bypass test done");
	endtask

	task automatic t_boundary();
		scan(1'b1, 8, INSTR_SAMPLE, 1'b0);
		scan(1'b0, 87, preload, 1'b1);
		chk(q[86:0], {pad_in, OE_RESET});
		chk(pad_out, core_pad_out);
		chk(enables, OE_RESET);
		scan(1'b1, 8, INSTR_EXTEST, 1'b0);
		repeat (4) @(posedge clk);
		chk(pad_out, preload[86:4]);
		chk(enables, preload[3:0]);
		$display("boundary test done");
	endtask

	// Five high mode-select edges, then test reset, then the hold bit
	task automatic t_resets();
		repeat (5) tk(1'b1);
		status(INSTR_IDCODE, TAP_RESET);
		chk({pad_out, enables}, {core_pad_out, OE_RESET});
		tk(1'b0);
		@(posedge clk);
		test_reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		status(INSTR_IDCODE, TAP_RESET);
		test_reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		tk(1'b0);
		wb(1'b1, CTRL_OFFSET, 32'h0000_0001);
		status(INSTR_IDCODE, TAP_RESET);
		wb(1'b1, CTRL_OFFSET, 32'h0000_0000);
		wb(1'b0, 8'h08, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		tk(1'b0);
		status(INSTR_IDCODE, TAP_IDLE);
		$display("reset test done");
	endtask

	// Mode-select walk, first step in bit 0
	task automatic walk(input int n, input logic [15:0] m);
		for (int k = 0; k < n; k++) begin
			tk(m[k]);
		end
	endtask

	// Pause and exit-2 states; an unshifted capture becomes the instruction
	task automatic t_walk();
		walk(4, 16'h0005);
		status(INSTR_IDCODE, PAUSE_DR);
		walk(9, 16'h00BD);
		status(INSTR_IDCODE, PAUSE_IR);
		walk(3, 16'h0003);
		status(IR_CAPTURE, TAP_IDLE);
		$display("walk test done");
	endtask

	initial begin
		bad_count = 0;
		checks_done = 0;
		reset_n = 1'b0;
		test_reset_n = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0000_0000;
		pad_in = 83'h3_C3C3_5A5A_0F0F_9696_A5A5;
		core_pad_out = 83'h1_2345_6789_ABCD_EF01_2345;
		preload = {83'h2_DEAD_BEEF_0123_4567_89AB, 4'hA};
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		test_reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		chk(enables, OE_RESET);
		tk(1'b0);
		t_ident();
		t_bypass();
		t_boundary();
		t_resets();
		t_walk();
		close_out();
	end
endmodule
